//--- src/hpi_pkg.sv
// hpi_pkg: shared constants and types of the hub port indicator block
package hpi_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS  = 20;                            // hclk period, 50 MHz
  localparam int BLINK_HALF_NS  = 250_000_000;                   // half period of a blink pattern
  localparam int BLINK_HALF_CYC = BLINK_HALF_NS / CLK_PERIOD_NS; // 12.5 M cycles
  localparam int MOD_HALF_NS    = 5_000;                         // half period of the led square wave
  localparam int MOD_HALF_CYC   = MOD_HALF_NS / CLK_PERIOD_NS;   // 250 cycles

  // register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_SEL     = 8'h04;
  localparam logic [7:0] REG_STATUS  = 8'h08;
  localparam logic [7:0] REG_HUBCHAR = 8'h0C;

  // field positions
  localparam int SEL_W           = 3;  // selector bits per port
  localparam int STAT_GREEN_LSB  = 0;  // lit green, one bit per port
  localparam int STAT_AMBER_LSB  = 8;  // lit amber
  localparam int STAT_BABBLE_LSB = 16; // live babble input
  localparam int STAT_OVC_LSB    = 24; // live overcurrent power-off input
  localparam int HUBCHAR_IND_BIT = 7;  // indicators present
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // control register, manual_en at bit 0
  typedef struct packed {
    logic ind_present;   // bit 4
    logic pol_amber_low; // bit 3
    logic pol_green_low; // bit 2
    logic mod_en;        // bit 1
    logic manual_en;     // bit 0
  } hpi_ctrl_t;
  localparam int        CTRL_W   = 5;
  localparam hpi_ctrl_t CTRL_RST = 5'h10; // automatic, steady, active high, present

  // port state machine states
  typedef enum logic [3:0] {
    PS_POWERED_OFF   = 4'h0,
    PS_DISCONNECTED  = 4'h1,
    PS_DISABLED      = 4'h2,
    PS_NOT_CONFIG    = 4'h3,
    PS_RESETTING     = 4'h4,
    PS_TESTING       = 4'h5,
    PS_ENABLED       = 4'h6,
    PS_TRANSMIT      = 4'h7,
    PS_TRANSMIT_R    = 4'h8,
    PS_SUSPENDED     = 4'h9,
    PS_RESUMING      = 4'hA,
    PS_SEND_EOR      = 4'hB,
    PS_RESTART_ES    = 4'hC
  } hpi_pstate_t;

  // manual indicator selector
  typedef enum logic [2:0] {
    SEL_OFF      = 3'h0, // not operational
    SEL_AMBER    = 3'h1, // error
    SEL_GREEN    = 3'h2, // fully operational
    SEL_BLINK_OG = 3'h3, // software attention
    SEL_BLINK_OA = 3'h4, // hardware attention
    SEL_BLINK_GA = 3'h5  // reserved meaning
  } hpi_sel_t;

  // per-port inputs from the port logic
  typedef struct packed {
    hpi_pstate_t state;   // port state
    logic        ovc_off; // powered off by overcurrent
    logic        babble;  // babble seen
  } hpi_port_in_t;

  // one indicator pair
  typedef struct packed {
    logic green;
    logic amber;
  } hpi_led_t;

  // settings shared by all ports
  typedef struct packed {
    logic manual; // host-driven colour
    logic mod_on; // square wave in its lit half
    logic blink;  // blink phase
    logic pol_g;  // green active low
    logic pol_a;  // amber active low
  } hpi_cfg_t;

endpackage

//--- src/hpi_tick.sv
// hpi_tick: free-running divider giving a one-cycle enable pulse
`timescale 1ns/1ps
`default_nettype none
module hpi_tick #(
  parameter int unsigned CYCLES = 250 // pulse period in hclk cycles
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // enable pulse
  output logic      tick
);
  localparam int unsigned  CW   = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;  // cycle counter
    logic          tick; // registered pulse
  } hpi_tick_st_t;

  hpi_tick_st_t st_q; // state
  hpi_tick_st_t st_d; // next state

  // wrap at LAST, pulse once per wrap
  always_comb begin
    st_d      = st_q;
    st_d.tick = (st_q.cnt == LAST);
    st_d.cnt  = (st_q.cnt == LAST) ? '0 : st_q.cnt + CW'(1);
  end

  // state register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick = st_q.tick;
endmodule // hpi_tick
`default_nettype wire

//--- src/hpi_port.sv
// hpi_port: colour selection, modulation and polarity for one port
`timescale 1ns/1ps
`default_nettype none
module hpi_port
  import hpi_pkg::*;
(
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // settings and port status
  input  wire hpi_cfg_t     cfg,
  input  wire hpi_sel_t     sel,
  input  wire hpi_port_in_t port_in,
  // indicator state
  output hpi_led_t          lit,
  output hpi_led_t          pin
);
  typedef struct packed {
    hpi_led_t lit; // logical colour
    hpi_led_t pin; // level at the pins
  } hpi_port_st_t;

  hpi_port_st_t st_q; // state
  hpi_port_st_t st_d; // next state

  // colour decode, then square wave, then polarity
  always_comb begin
    st_d     = st_q;
    st_d.lit = '0;
    if (cfg.manual) begin
      unique case (sel) // R6 R8
        SEL_OFF:      ;
        SEL_AMBER:    st_d.lit.amber = 1'b1;
        SEL_GREEN:    st_d.lit.green = 1'b1;
        SEL_BLINK_OG: st_d.lit.green = cfg.blink; // R7
        SEL_BLINK_OA: st_d.lit.amber = cfg.blink; // R7
        SEL_BLINK_GA: begin
          // colours take turns, never both
          st_d.lit.green = cfg.blink;  // R13
          st_d.lit.amber = !cfg.blink; // R13
        end
        default:      ; // spare codes stay dark
      endcase
    end else begin
      // automatic: steady colours only, blink ignored
      unique case (port_in.state) // R11
        PS_POWERED_OFF: st_d.lit.amber = port_in.ovc_off; // R1
        PS_ENABLED, PS_TRANSMIT, PS_TRANSMIT_R: st_d.lit.green = 1'b1; // R3
        PS_DISCONNECTED, PS_DISABLED, PS_NOT_CONFIG, PS_RESETTING, PS_TESTING,
        PS_SUSPENDED, PS_RESUMING, PS_SEND_EOR, PS_RESTART_ES: ; // R2
        default: ; // illegal state code, dark
      endcase
    end
    // dark half of the square wave saves led power
    if (!cfg.mod_on) begin
      st_d.lit = '0; // R4
    end
    st_d.pin.green = st_d.lit.green ^ cfg.pol_g; // R5
    st_d.pin.amber = st_d.lit.amber ^ cfg.pol_a; // R5
  end

  // reset puts the pins at the default inactive level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '0; // R14
    end else begin
      st_q <= st_d;
    end
  end

  assign lit = st_q.lit;
  assign pin = st_q.pin;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_auto_hold;
    !cfg.manual && cfg.mod_on && $stable(port_in);
  endsequence

  a_auto_powoff: assert property ((!cfg.manual && cfg.mod_on && port_in.state == PS_POWERED_OFF)
      |=> st_q.lit.amber == $past(port_in.ovc_off) && !st_q.lit.green) // R1
    else $error("powered-off port shows wrong colour");
  a_auto_dark: assert property ((!cfg.manual && port_in.state inside {PS_DISCONNECTED, PS_DISABLED,
      PS_NOT_CONFIG, PS_RESETTING, PS_TESTING, PS_SUSPENDED, PS_RESUMING, PS_SEND_EOR,
      PS_RESTART_ES}) |=> st_q.lit == '0) // R2
    else $error("indicator lit in a dark port state");
  a_auto_green: assert property ((!cfg.manual && cfg.mod_on
      && port_in.state inside {PS_ENABLED, PS_TRANSMIT, PS_TRANSMIT_R})
      |=> st_q.lit.green && !st_q.lit.amber) // R3
    else $error("enabled port not green");
  a_mod_dark: assert property (!cfg.mod_on |=> st_q.lit == '0) // R4
    else $error("led lit in dark half of square wave");
  a_pol_invert: assert property (1'b1 |=> (st_q.pin.green ^ st_q.lit.green) == $past(cfg.pol_g)
      && (st_q.pin.amber ^ st_q.lit.amber) == $past(cfg.pol_a)) // R5
    else $error("pin polarity does not follow setting");
  a_manual_green: assert property ((cfg.manual && cfg.mod_on && sel == SEL_GREEN)
      |=> st_q.lit.green && !st_q.lit.amber) // R6
    else $error("manual green not shown");
  a_blink_alt: assert property ((cfg.manual && cfg.mod_on && sel == SEL_BLINK_GA)
      |=> st_q.lit.green == $past(cfg.blink) && st_q.lit.amber != $past(cfg.blink)) // R7
    else $error("green/amber blink does not alternate");
  a_auto_steady: assert property (s_auto_hold ##1 s_auto_hold |=> $stable(st_q.lit)) // R11
    else $error("automatic mode colour changed without cause");
  a_colour_excl: assert property (!(st_q.lit.green && st_q.lit.amber)) // R13
    else $error("green and amber lit together");
endmodule // hpi_port
`default_nettype wire

//--- src/hpi_ctrl.sv
// hpi_ctrl: port indicator controller with its AHB-Lite register slave
//
// Function
// R1: powered-off port: amber if overcurrent, else off
// R2: auto mode: listed inactive port states stay dark
// R3: auto mode: enabled or transmitting ports show green
// R4: optional square-wave modulation of led lines
// R5: per-colour output polarity set by configuration
// R6: manual mode: host selects each port's colour
// R7: manual mode supports blink and steady patterns
// R8: manual colour codes carry the standard meanings
// R9: host blinks green on babble, amber on overcurrent
// R10: power-up starts in automatic mode
// R11: automatic mode never blinks
// R12: hub characteristics bit 7 reports indicators present
// R13: green and amber never lit together
// R14: reset drives all pins to inactive level
//
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module hpi_ctrl
  import hpi_pkg::*;
#(
  parameter int unsigned NPORTS            = 4,            // downstream ports, at most 8
  parameter int unsigned BLINK_HALF_CYCLES = BLINK_HALF_CYC, // blink half period
  parameter int unsigned MOD_HALF_CYCLES   = MOD_HALF_CYC    // square wave half period
) (
  // clock and reset
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  // ahb-lite slave
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic                            hreadyout,
  output logic                            hresp,
  output logic [31:0]                     hrdata,
  // port status from the hub port logic
  input  wire hpi_port_in_t [NPORTS-1:0]  port_in,
  // indicator pins and descriptor bit
  output hpi_led_t [NPORTS-1:0]           led_out,
  output logic                            hub_char_ind
);
  localparam int SEL_BITS = SEL_W * NPORTS;

  typedef struct packed {
    logic                live;     // low only in the first cycle after reset
    logic                wr_pend;  // write data phase pending
    logic [7:0]          wr_addr;  // address of that write
    logic [31:0]         rdata;    // read data for the data phase
    hpi_ctrl_t           ctrl;     // control register
    logic [SEL_BITS-1:0] sel;      // manual selectors
    logic                mod_ph;   // square wave phase
    logic                blink_ph; // blink phase
  } hpi_top_st_t;

  hpi_top_st_t            st_q;       // state
  hpi_top_st_t            st_d;       // next state
  logic                   tick_mod;   // square wave half-period pulse
  logic                   tick_blink; // blink half-period pulse
  logic                   acc;        // address phase accepted
  logic [31:0]            stat_word;  // status register view
  hpi_cfg_t               cfg;        // settings for the ports
  hpi_led_t [NPORTS-1:0]  lit;        // logical colours

  // slower rates as enable pulses
  hpi_tick #(
    .CYCLES (MOD_HALF_CYCLES)
  ) u_mod_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick_mod)
  );

  hpi_tick #(
    .CYCLES (BLINK_HALF_CYCLES)
  ) u_blink_tick (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (tick_blink)
  );

  // zero wait state slave, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign acc       = hsel && htrans[1] && hready;

  // settings seen by every port
  always_comb begin
    cfg.manual = st_q.ctrl.manual_en;
    cfg.mod_on = !st_q.ctrl.mod_en || st_q.mod_ph; // R4
    cfg.blink  = st_q.blink_ph;
    cfg.pol_g  = st_q.ctrl.pol_green_low; // R5
    cfg.pol_a  = st_q.ctrl.pol_amber_low; // R5
  end

  // status word: lit colours and live inputs
  always_comb begin
    stat_word = '0;
    for (int i = 0; i < NPORTS; i++) begin
      stat_word[STAT_GREEN_LSB + i]  = lit[i].green;
      stat_word[STAT_AMBER_LSB + i]  = lit[i].amber;
      stat_word[STAT_BABBLE_LSB + i] = port_in[i].babble;
      stat_word[STAT_OVC_LSB + i]    = port_in[i].ovc_off;
    end
  end

  // register file and bus sequencing
  always_comb begin
    logic [31:0] hc; // hub characteristics view
    hc          = '0;
    st_d        = st_q;
    st_d.live   = 1'b1;
    st_d.wr_pend = 1'b0;
    if (tick_mod) begin
      st_d.mod_ph = !st_q.mod_ph;
    end
    if (tick_blink) begin
      st_d.blink_ph = !st_q.blink_ph;
    end
    // write data arrives one cycle after its address
    if (st_q.wr_pend) begin
      case (st_q.wr_addr)
        REG_CTRL: st_d.ctrl = hpi_ctrl_t'(hwdata[CTRL_W-1:0]); // R6 R12
        REG_SEL:  st_d.sel  = hwdata[SEL_BITS-1:0];            // R6
        default:  ; // read-only or unmapped, ignored
      endcase
    end
    if (acc) begin
      // only whole-word writes change a register
      st_d.wr_pend = hwrite && (hsize == HSIZE_WORD);
      st_d.wr_addr = haddr[7:0];
      if (!hwrite) begin
        // next-state view, so a read right after a write sees it
        hc[HUBCHAR_IND_BIT] = st_d.ctrl.ind_present; // R12
        case (haddr[7:0])
          REG_CTRL:    st_d.rdata = 32'(st_d.ctrl);
          REG_SEL:     st_d.rdata = 32'(st_d.sel);
          REG_STATUS:  st_d.rdata = stat_word;
          REG_HUBCHAR: st_d.rdata = hc;
          default:     st_d.rdata = '0; // unmapped reads zero
        endcase
      end
    end
  end

  // state register, automatic mode after reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= '{ctrl: CTRL_RST, default: '0}; // R10
    end else begin
      st_q <= st_d;
    end
  end

  assign hrdata       = st_q.rdata;
  assign hub_char_ind = st_q.ctrl.ind_present; // R12

  // one colour engine per port
  for (genvar g = 0; g < NPORTS; g++) begin : g_port
    hpi_port u_port (
      .hclk    (hclk),
      .hresetn (hresetn),
      .cfg     (cfg),
      .sel     (hpi_sel_t'(st_q.sel[g*SEL_W +: SEL_W])),
      .port_in (port_in[g]),
      .lit     (lit[g]),
      .pin     (led_out[g])
    );
  end

  a_reset_auto: assert property (@(posedge hclk) disable iff (!hresetn) // R10
      !st_q.live |-> !st_q.ctrl.manual_en && st_q.ctrl.ind_present)
    else $error("not in automatic mode after reset");
  a_reset_dark: assert property (@(posedge hclk) disable iff (!hresetn) // R14
      !st_q.live |-> led_out == '0)
    else $error("indicator pins active right after reset");
  a_hubchar_bit: assert property (@(posedge hclk) disable iff (!hresetn) // R12
      (acc && !hwrite && haddr[7:0] == REG_HUBCHAR)
      |=> hrdata == 32'(hub_char_ind) << HUBCHAR_IND_BIT)
    else $error("hub characteristics bit 7 wrong");
endmodule // hpi_ctrl
`default_nettype wire

//--- verification/hpi_led_model.sv
// hpi_led_model: green and amber lamps hanging on each port's indicator pins
`timescale 1ns/1ps
`default_nettype none
module hpi_led_model
  import hpi_pkg::*;
#(
  parameter int NPORTS = 4 // ports wired to lamps
) (
  // pin levels and how the lamps are wired
  input  wire hpi_led_t [NPORTS-1:0] led_out,
  input  wire logic                  pol_g,
  input  wire logic                  pol_a,
  // which lamps glow
  output var  hpi_led_t [NPORTS-1:0] glow
);
  // a lamp tied to the supply glows on a low pin, so wiring undoes the polarity
  always_comb begin
    for (int i = 0; i < NPORTS; i++) begin
      glow[i] = led_out[i] ^ {pol_g, pol_a};
    end
  end
endmodule // hpi_led_model
`default_nettype wire

//--- verification/test_hub_port_indicator_control.sv
// test_hub_port_indicator_control: self-checking bench of the port indicator controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin failures++; \
  $display("mismatch %s exp %h got %h", nm, ex, got); end end
module test_hub_port_indicator_control
  import hpi_pkg::*;
;
  localparam int NP = 4; // ports under test
  // bus and clock
  logic                  hclk = 1'b0;
  logic                  hresetn = 1'b0;
  logic                  hsel, hwrite, hreadyout, hresp, hub_char_ind;
  logic [1:0]            htrans;
  logic [2:0]            hsize;
  logic [31:0]           haddr, hwdata, hrdata, rd;
  // port side and lamps
  hpi_port_in_t [NP-1:0] pin_q;
  hpi_led_t [NP-1:0]     led_out, glow;
  logic                  pol_g, pol_a; // lamp wiring, follows what ctrl was given
  logic [3:0]            seen;         // lamp pairs seen, indexed by {green, amber}
  int                    failures, tests_run, cyc;

  always #10 hclk = ~hclk;

  // short counts keep blink and square wave visible within a few dozen cycles
  hpi_ctrl #(.NPORTS(NP), .BLINK_HALF_CYCLES(8), .MOD_HALF_CYCLES(4)) hpi_ctrl_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .port_in(pin_q),
    .led_out(led_out), .hub_char_ind(hub_char_ind));

  hpi_led_model #(.NPORTS(NP)) hpi_led_model_i (
    .led_out(led_out), .pol_g(pol_g), .pol_a(pol_a), .glow(glow));

  // verdict and end of run
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // hang guard, well above the ~750 cycles the run needs
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      complete_run();
    end
  end

  // one single transfer; no wait count assumed, hready decides
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [2:0] sz);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    hsize  <= sz;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata; // taken at the edge closing the data phase
    `CHK("hresp", 1'b0, hresp)
  endtask

  // lamp pair expected in automatic mode, before polarity
  function automatic hpi_led_t exp_auto(hpi_port_in_t p);
    case (p.state)
      PS_POWERED_OFF: return {1'b0, p.ovc_off};
      PS_ENABLED, PS_TRANSMIT, PS_TRANSMIT_R: return 2'h2;
      default: return 2'h0;
    endcase
  endfunction

  // set of lamp pairs a selector code should show over a full blink period
  function automatic logic [3:0] exp_seen(int c);
    case (c)
      1: return 4'h2;        // amber
      2: return 4'h4;        // green
      3: return 4'h5;        // off and green
      4: return 4'h3;        // off and amber
      5: return 4'h6;        // green and amber, never both
      default: return 4'h1;  // off, spare codes too
    endcase
  endfunction

  // pins and status word against the automatic mapping
  task automatic chk_auto();
    hpi_led_t    e;  // expected pair
    logic [31:0] st; // expected status word
    st = '0;
    for (int i = 0; i < NP; i++) begin
      e = exp_auto(pin_q[i]);
      `CHK("led", e ^ {pol_g, pol_a}, led_out[i])
      st[i] = e.green;
      st[8+i] = e.amber;
      st[16+i] = pin_q[i].babble;
      st[24+i] = pin_q[i].ovc_off;
    end
    ahb(1'b0, REG_STATUS, 32'h0, HSIZE_WORD);
    `CHK("status", st, rd)
  endtask

  // collect lamp pairs over more than two blink halves
  task automatic watch();
    seen = '0;
    repeat (3) @(posedge hclk);
    repeat (20) begin
      @(posedge hclk);
      seen[glow[0]] = 1'b1;
      seen[glow[NP-1]] = 1'b1;
    end
  endtask

  initial begin
    rd = $urandom(32'hC18254F4);
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = HSIZE_WORD;
    pin_q = '0;
    {pol_g, pol_a} = 2'h0;
    {failures, tests_run, cyc} = '0;
    repeat (4) @(posedge hclk);
    `CHK("rst led", '0, led_out)
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK("char pin", 1'b1, hub_char_ind)
    ahb(1'b0, REG_CTRL, 32'h0, HSIZE_WORD);
    `CHK("ctrl rst", 32'h10, rd)
    ahb(1'b0, REG_HUBCHAR, 32'h0, HSIZE_WORD);
    `CHK("hubchar", 32'h80, rd)
    ahb(1'b0, 8'h40, 32'h0, HSIZE_WORD);
    `CHK("unmapped", 32'h0, rd)
    // automatic mode: port 0 walks every state, the rest random, both polarities
    for (int k = 0; k < 64; k++) begin
      if (k == 32) begin
        ahb(1'b1, REG_CTRL, 32'h1C, HSIZE_WORD);
        {pol_g, pol_a} = 2'h3;
      end
      if (k == 40) ahb(1'b1, REG_CTRL, 32'h10, 3'h0); // byte write, must be ignored
      if (k == 48) ahb(1'b1, REG_STATUS, 32'hFFFFFFFF, HSIZE_WORD); // read-only
      if (k == 56) begin
        // only green inverted, so swapped colour polarities show up
        ahb(1'b1, REG_CTRL, 32'h14, HSIZE_WORD);
        {pol_g, pol_a} = 2'h2;
      end
      @(posedge hclk);
      for (int i = 0; i < NP; i++) begin
        pin_q[i] <= '{state: hpi_pstate_t'((k % 32 < 13 && i == 0) ? k % 32 : $urandom_range(12)),
                      ovc_off: 1'($urandom_range(1)), babble: 1'($urandom_range(1))};
      end
      repeat (3) @(posedge hclk);
      chk_auto();
    end
    // automatic green is steady, then square-wave modulated
    ahb(1'b1, REG_CTRL, 32'h10, HSIZE_WORD);
    {pol_g, pol_a} = 2'h0;
    for (int i = 0; i < NP; i++) pin_q[i] <= '{PS_ENABLED, 1'b0, 1'b0};
    watch();
    `CHK("auto steady", 4'h4, seen)
    ahb(1'b1, REG_CTRL, 32'h12, HSIZE_WORD);
    watch();
    `CHK("modulated", 4'h5, seen)
    // manual mode: every selector code set on every port as the host would, lamps of ports 0 and NP-1 checked
    ahb(1'b1, REG_CTRL, 32'h11, HSIZE_WORD);
    for (int c = 0; c < 8; c++) begin
      ahb(1'b1, REG_SEL, {20'h0, {4{c[2:0]}}}, HSIZE_WORD);
      watch();
      `CHK("manual", exp_seen(c), seen)
    end
    // reset in mid-run darkens every pin and restores automatic mode
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    `CHK("rst led", '0, led_out)
    hresetn <= 1'b1;
    ahb(1'b0, REG_CTRL, 32'h0, HSIZE_WORD);
    `CHK("ctrl rst", 32'h10, rd)
    // indicators reported absent once configuration clears the bit
    ahb(1'b1, REG_CTRL, 32'h0, HSIZE_WORD);
    ahb(1'b0, REG_HUBCHAR, 32'h0, HSIZE_WORD);
    `CHK("hubchar", 32'h0, rd)
    `CHK("char pin", 1'b0, hub_char_ind)
    complete_run();
  end
endmodule // test_hub_port_indicator_control
`default_nettype wire
